// ===== hdl/dcsf_top.sv
// Dual-clock elastic sample FIFO with strobe-driven pointer resets.
// Write side on input_latch_clock, read side on clock; cfg static.
module dcsf_top (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               input_latch_clock,
  input  wire logic               in_valid,
  input  dcsf_pkg::dcsf_smp_t     in_sample,
  input  wire logic               input_pointer_strobe,
  input  wire logic               sync_strobe,
  input  wire logic               serial_port_align_strobe,
  input  wire logic               output_pointer_strobe,
  input  dcsf_pkg::dcsf_cfg_t     cfg,
  input  wire logic               out_ready,
  output logic                    out_valid,
  output dcsf_pkg::dcsf_smp_t     out_sample,
  output logic                    collision_alarm,
  output logic                    pll_div_reset
);
  import dcsf_pkg::*;

  // ==========================================
  // Storage
  dcsf_smp_t mem [DEPTH];

  // ==========================================
  // Link domain synchronisers
  logic [LSYNC_W-1:0] ls1_q;
  logic [LSYNC_W-1:0] ls2_q;
  wire  [LSYNC_W-1:0] ls_in = {cfg.wr_src, serial_port_align_strobe,
                               sync_strobe, input_pointer_strobe, srst};

  always_ff @(posedge input_latch_clock) begin
    ls1_q <= ls_in;
    ls2_q <= ls1_q;
  end

  wire          lrst      = ls2_q[0];
  wire          l_instb   = ls2_q[1];
  wire          l_sync    = ls2_q[2];
  wire          l_sif     = ls2_q[3];
  wire    [1:0] l_wr_src  = ls2_q[5:4];

  // ==========================================
  // Write pointer reset source
  wire wr_lvl = (l_wr_src == DCSF_WR_SIF)  ? l_sif :
                (l_wr_src == DCSF_WR_SYNC) ? l_sync :
                l_instb;

  logic wr_lvl_q;
  always_ff @(posedge input_latch_clock) begin
    if (lrst) wr_lvl_q <= 1'b0;
    else      wr_lvl_q <= wr_lvl;
  end

  wire wr_edge = wr_lvl & ~wr_lvl_q;

  // ==========================================
  // Write pointer and storage
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] wr_ptr_d;
  logic [PTR_W-1:0] wr_gray_q;
  wire  [PTR_W-1:0] wr_base = wr_edge ? WR_RST_POS : wr_ptr_q;

  assign wr_ptr_d = in_valid ? PTR_W'(wr_base + PTR_ONE) : wr_base;

  always_ff @(posedge input_latch_clock) begin
    if (lrst) begin
      wr_ptr_q  <= WR_RST_POS;
      wr_gray_q <= WR_RST_POS;
    end else begin
      wr_ptr_q  <= wr_ptr_d;
      wr_gray_q <= wr_ptr_d ^ (wr_ptr_d >> 1);
    end
  end

  always_ff @(posedge input_latch_clock) begin
    if (in_valid) mem[wr_base] <= in_sample;
  end

  // ==========================================
  // Conversion domain synchronisers
  logic [CSYNC_W-1:0] cs1_q;
  logic [CSYNC_W-1:0] cs2_q;
  wire  [CSYNC_W-1:0] cs_in = {wr_gray_q, wr_lvl_q, output_pointer_strobe,
                               sync_strobe, input_pointer_strobe};

  always_ff @(posedge clock) begin
    cs1_q <= cs_in;
    cs2_q <= cs1_q;
  end

  wire             c_instb  = cs2_q[0];
  wire             c_sync   = cs2_q[1];
  wire             c_outstb = cs2_q[2];
  wire             c_wrlvl = cs2_q[3];
  wire [PTR_W-1:0] c_gray  = cs2_q[6:4];
  wire [PTR_W-1:0] c_wbin  = {c_gray[2], c_gray[2] ^ c_gray[1],
                              c_gray[2] ^ c_gray[1] ^ c_gray[0]};

  // ==========================================
  // Output side tick
  logic [DIV_W-1:0] div_q;
  wire  [DIV_W-1:0] n_ext   = {1'b0, cfg.interp};
  wire  [DIV_W-1:0] div_top = cfg.word_wide ? DIV_W'((n_ext << 1) - DIV_ONE)
                                            : DIV_W'(n_ext - DIV_ONE);
  wire              tick    = (div_q >= div_top);

  always_ff @(posedge clock) begin
    if (srst || tick) div_q <= DIV_RST;
    else              div_q <= DIV_W'(div_q + DIV_ONE);
  end

  // ==========================================
  // Read pointer reset source
  wire rd_lvl = (cfg.rd_src == DCSF_RD_SINGLE) ? c_wrlvl :
                (cfg.rd_src == DCSF_RD_OUTSTB) ? c_outstb :
                (cfg.rd_src == DCSF_RD_SYNC)   ? c_sync :
                c_instb;

  logic rd_smp_q;
  always_ff @(posedge clock) begin
    if (srst)      rd_smp_q <= 1'b0;
    else if (tick) rd_smp_q <= rd_lvl;
  end

  wire rd_edge = tick & rd_lvl & ~rd_smp_q;

  // ==========================================
  // Read pointer, collision alarm
  logic [PTR_W-1:0] rd_ptr;
  wire              buf_ready;
  wire              push    = tick & ~rd_edge & buf_ready;
  dcsf_smp_t        rd_data;
  assign rd_data = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (srst || rd_edge) rd_ptr <= RD_RST_POS;
    else if (push)       rd_ptr <= PTR_W'(rd_ptr + PTR_ONE);
  end

  wire coll_d = (c_wbin == rd_ptr);

  always_ff @(posedge clock) begin
    if (srst)      collision_alarm <= 1'b0;
    else if (tick) collision_alarm <= coll_d;
  end

  // ==========================================
  // Divider reset, sync strobe only
  logic c_sync_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      c_sync_q      <= 1'b0;
      pll_div_reset <= 1'b0;
    end else begin
      c_sync_q      <= c_sync;
      pll_div_reset <= c_sync & ~c_sync_q;
    end
  end

  // ==========================================
  // Two-entry output buffer
  logic      t_v_q;
  dcsf_smp_t t_d_q;
  wire       pop    = out_valid & out_ready;
  wire       h_keep = pop ? t_v_q : out_valid;
  wire       h_v_d  = h_keep | push;
  wire       t_v_d  = ~pop & (t_v_q | (out_valid & push));
  dcsf_smp_t h_src;
  dcsf_smp_t h_d_d;
  dcsf_smp_t t_d_d;
  assign buf_ready = ~t_v_q;
  assign h_src     = pop ? t_d_q : out_sample;
  assign h_d_d     = h_keep ? h_src : rd_data;
  assign t_d_d     = (push & out_valid & ~pop) ? rd_data : t_d_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      out_valid <= 1'b0;
      t_v_q     <= 1'b0;
    end else begin
      out_valid <= h_v_d;
      t_v_q     <= t_v_d;
    end
  end

  always_ff @(posedge clock) begin
    out_sample <= h_d_d;
    t_d_q      <= t_d_d;
  end

  // ==========================================
  // Checks, conversion domain
  sequence s_rd_strobe;
    tick && rd_lvl && !rd_smp_q;
  endsequence

  property p_rd_reset;
    @(posedge clock) disable iff (srst)
      s_rd_strobe |=> (rd_ptr == RD_RST_POS);
  endproperty

  a_rd_reset_pos: assert property (p_rd_reset)
    else $error("read pointer not at four after reset strobe");

  a_rd_only_tick: assert property (
    @(posedge clock) disable iff (srst)
      $changed(rd_smp_q) |-> $past(tick))
    else $error("read strobe sampled off the output tick");

  a_rd_ptr_step: assert property (
    @(posedge clock) disable iff (srst)
      push |=> (rd_ptr == PTR_W'($past(rd_ptr) + PTR_ONE)))
    else $error("read pointer did not step by one");

  a_rd_ptr_hold: assert property (
    @(posedge clock) disable iff (srst)
      (!tick && !$past(srst)) |=> $stable(rd_ptr))
    else $error("read pointer moved without a tick");

  a_tick_period: assert property (
    @(posedge clock) disable iff (srst)
      tick |-> (div_q == div_top) || $past(srst) || $changed(cfg))
    else $error("output tick not at divider terminal count");

  sequence s_sync_rise;
    c_sync && !c_sync_q;
  endsequence

  a_pll_sync_only: assert property (
    @(posedge clock) disable iff (srst)
      pll_div_reset |-> $past(c_sync) && !$past(c_sync_q))
    else $error("divider reset without a sync rising edge");

  a_pll_on_sync: assert property (
    @(posedge clock) disable iff (srst)
      s_sync_rise |=> pll_div_reset ##1 !pll_div_reset)
    else $error("sync rising edge gave no one-cycle divider reset");

  a_alarm_match: assert property (
    @(posedge clock) disable iff (srst)
      tick |=> (collision_alarm == $past(coll_d)))
    else $error("collision alarm disagrees with pointer compare");

  a_out_hold: assert property (
    @(posedge clock) disable iff (srst)
      (out_valid && !out_ready) |=> out_valid && $stable(out_sample))
    else $error("output word dropped under back-pressure");

  a_buf_stall: assert property (
    @(posedge clock) disable iff (srst)
      (tick && t_v_q && !rd_edge) |=> $stable(rd_ptr))
    else $error("read pointer moved while buffer full");

  // ==========================================
  // Checks, link domain
  a_wr_reset_zero: assert property (
    @(posedge input_latch_clock) disable iff (lrst)
      (wr_edge && !in_valid) |=> (wr_ptr_q == WR_RST_POS))
    else $error("write pointer not at zero after reset strobe");

  a_wr_ptr_step: assert property (
    @(posedge input_latch_clock) disable iff (lrst)
      (in_valid && !wr_edge) |=> (wr_ptr_q == PTR_W'($past(wr_ptr_q) + PTR_ONE)))
    else $error("write pointer did not step by one");

  a_wr_sif_src: assert property (
    @(posedge input_latch_clock) disable iff (lrst)
      (l_wr_src == DCSF_WR_SIF) |-> (wr_lvl == l_sif))
    else $error("write reset not taken from align strobe");

endmodule

// ===== include/dcsf_pkg.sv
// Constants and types of the dual-clock sample FIFO.
// Assumes a conversion-domain clock and a free-running input latch clock.
package dcsf_pkg;

  // ==========================================
  // Sizes and reset positions
  localparam int SMP_W = 16;
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int N_W   = 5;
  localparam int DIV_W = 6;
  localparam logic [PTR_W-1:0] WR_RST_POS = 3'h0;
  localparam logic [PTR_W-1:0] RD_RST_POS = 3'h4;
  localparam logic [PTR_W-1:0] PTR_ONE    = 3'h1;
  localparam logic [DIV_W-1:0] DIV_RST    = 6'h00;
  localparam logic [DIV_W-1:0] DIV_ONE    = 6'h01;
  localparam int LSYNC_W = 6;
  localparam int CSYNC_W = 7;

  // ==========================================
  // Types
  typedef struct packed {
    logic [SMP_W-1:0] chan_a;
    logic [SMP_W-1:0] chan_b;
  } dcsf_smp_t;

  typedef enum logic [1:0] {
    DCSF_WR_INSTB,
    DCSF_WR_SYNC,
    DCSF_WR_SIF
  } dcsf_wr_src_t;

  typedef enum logic [1:0] {
    DCSF_RD_INSTB,
    DCSF_RD_SYNC,
    DCSF_RD_OUTSTB,
    DCSF_RD_SINGLE
  } dcsf_rd_src_t;

  typedef struct packed {
    logic [N_W-1:0] interp;
    logic           word_wide;
    dcsf_wr_src_t   wr_src;
    dcsf_rd_src_t   rd_src;
  } dcsf_cfg_t;

endpackage

// ===== testbench/dcsf_src_model.sv
// Sample source model for the dual-clock sample FIFO.
// Assumes the bench raises hold around the pointer reset strobes of t_ptr_reset.
module dcsf_src_model (
  output logic                input_latch_clock,
  input  wire logic           hold,
  output logic                in_valid,
  output dcsf_pkg::dcsf_smp_t in_sample
);
  timeunit 1ns;
  timeprecision 100ps;
  import dcsf_pkg::*;

  logic [2:0] slot_q;

  // ==========================================
  // Forwarded latch clock, free running
  initial begin
    input_latch_clock = 1'b0;
    #1.7;
    forever #3 input_latch_clock = ~input_latch_clock;
  end

  // ==========================================
  // Word tagged with the slot it should land in
  initial begin
    in_valid  = 1'b0;
    in_sample = '0;
    slot_q    = 3'h0;
  end

  always @(posedge input_latch_clock) begin
    if (hold) begin
      in_valid  <= 1'b0;
      in_sample <= ~in_sample;
      slot_q    <= 3'h0;
    end else begin
      in_valid  <= 1'b1;
      in_sample <= {13'h1400, slot_q, 13'h0B4A, slot_q};
      slot_q    <= slot_q + 3'h1;
    end
  end
endmodule

// ===== testbench/tb_dcsf_top.sv
// Self-checking bench of the dual-clock sample FIFO.
// Assumes the source model writes a slot tag into every word.
module tb_dcsf_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dcsf_pkg::*;

  logic       clock;
  logic       srst;
  logic       hold;
  logic       out_ready;
  logic [3:0] stb;
  dcsf_cfg_t  cfg;
  logic       input_latch_clock;
  logic       in_valid;
  dcsf_smp_t  in_sample;
  logic       out_valid;
  dcsf_smp_t  out_sample;
  logic       collision_alarm;
  logic       pll_div_reset;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         pll_cnt = 0;

  dcsf_src_model src (
    .input_latch_clock(input_latch_clock),
    .hold             (hold),
    .in_valid         (in_valid),
    .in_sample        (in_sample)
  );

  dcsf_top dut (
    .clock                   (clock),
    .srst                    (srst),
    .input_latch_clock       (input_latch_clock),
    .in_valid                (in_valid),
    .in_sample               (in_sample),
    .input_pointer_strobe    (stb[3]),
    .sync_strobe             (stb[2]),
    .serial_port_align_strobe(stb[1]),
    .output_pointer_strobe   (stb[0]),
    .cfg                     (cfg),
    .out_ready               (out_ready),
    .out_valid               (out_valid),
    .out_sample              (out_sample),
    .collision_alarm         (collision_alarm),
    .pll_div_reset           (pll_div_reset)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (pll_div_reset === 1'b1) pll_cnt++;
  end

  // ==========================================
  // Shared helpers
  function automatic dcsf_cfg_t mk(dcsf_wr_src_t w, dcsf_rd_src_t r, logic [4:0] n, logic ww);
    return '{interp: n, word_wide: ww, wr_src: w, rd_src: r};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Source held idle through reset, then hold set to h once the link side is out of it
  task automatic reset_dut(input dcsf_cfg_t c, input logic h);
    @(posedge clock);
    hold <= 1'b1;
    cfg <= c;
    srst <= 1'b1;
    out_ready <= 1'b0;
    repeat (12) @(posedge clock);
    check({29'h0, out_valid, collision_alarm, pll_div_reset}, 32'h0);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    hold <= h;
  endtask

  // Pops skip stale words, then expects consecutive slot tags
  task automatic pop_run(input int skip, input int n, input logic [2:0] first);
    int k;
    out_ready <= 1'b1;
    for (int i = 0; i < skip + n; i++) begin
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (out_valid !== 1'b1 && k < 50);
      if (i >= skip) check(out_sample, {13'h1400, first + 3'(i - skip), 13'h0B4A, first + 3'(i - skip)});
    end
    out_ready <= 1'b0;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_rate(input logic [4:0] n, input logic ww);
    int c;
    int e;
    reset_dut(mk(DCSF_WR_INSTB, DCSF_RD_INSTB, n, ww), 1'b0);
    out_ready <= 1'b1;
    repeat (10) @(posedge clock);
    c = 0;
    repeat (60) @(posedge clock) if (out_valid === 1'b1) c++;
    out_ready <= 1'b0;
    e = 60 / (n * (ww ? 2 : 1));
    if (c == e - 1 || c == e + 1) c = e;
    check(32'(c), 32'(e));
  endtask

  task automatic t_alarm;
    int h0;
    int h1;
    reset_dut(mk(DCSF_WR_INSTB, DCSF_RD_INSTB, 5'h01, 1'b0), 1'b1);
    h0 = 0;
    h1 = 0;
    repeat (20) @(posedge clock) if (collision_alarm !== 1'b0) h0++;
    out_ready <= 1'b1;
    repeat (20) @(posedge clock) if (collision_alarm === 1'b1) h1++;
    out_ready <= 1'b0;
    check(32'(h0), 32'h0);
    check(32'(h1 != 0), 32'h1);
  endtask

  task automatic t_ptr_reset(input dcsf_cfg_t c, input logic [3:0] m);
    reset_dut(c, 1'b0);
    repeat (30) @(posedge clock);
    pop_run(2, 10, 3'h6);
    hold <= 1'b1;
    repeat (4) @(posedge clock);
    stb <= m;
    repeat (20) @(posedge clock);
    stb <= 4'h0;
    repeat (10) @(posedge clock);
    hold <= 1'b0;
    repeat (30) @(posedge clock);
    pop_run(2, 6, 3'h4);
  endtask

  task automatic t_pll(input logic [3:0] m, input int e);
    int c0;
    c0 = pll_cnt;
    stb <= m;
    repeat (20) @(posedge clock);
    stb <= 4'h0;
    repeat (10) @(posedge clock);
    check(32'(pll_cnt - c0), 32'(e));
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    srst = 1'b1;
    hold = 1'b1;
    out_ready = 1'b0;
    stb = 4'h0;
    cfg = mk(DCSF_WR_INSTB, DCSF_RD_INSTB, 5'h01, 1'b0);
    t_rate(5'h03, 1'b0);
    t_rate(5'h03, 1'b1);
    t_alarm();
    t_ptr_reset(mk(DCSF_WR_INSTB, DCSF_RD_INSTB, 5'h01, 1'b0), 4'h8);
    t_ptr_reset(mk(DCSF_WR_SYNC, DCSF_RD_SYNC, 5'h01, 1'b0), 4'h4);
    t_ptr_reset(mk(DCSF_WR_SIF, DCSF_RD_OUTSTB, 5'h01, 1'b0), 4'h3);
    t_ptr_reset(mk(DCSF_WR_INSTB, DCSF_RD_SINGLE, 5'h01, 1'b0), 4'h8);
    t_pll(4'h8, 0);
    t_pll(4'h4, 1);
    results();
  end

  initial begin
    #50us;
    error_cnt++;
    results();
  end
endmodule
